// [rtl/pcdc_phy_config_diag.v]
// phy configuration and diagnostic control: straps, isolate, indicator, duplex,
// loopback and pseudo-random self test, with a simple register port
// assumes all inputs synchronous to SYS_CLK and an outside mgmt frame decoder
// that issues one-cycle read/write strobes with a 5-bit register address
// Operation
// RL1 - straps load address field of phy control at every reset
// RL2 - answer management at strapped address, 0 to 31
// RL3 - strapped address 0 isolates; written address 0 does not
// RL4 - address defaults to one when no straps fitted
// RL5 - basic control bit 10 also isolates
// RL6 - isolate ignores transmit inputs and floats mac-facing outputs
// RL7 - management keeps working in isolate
// RL8 - isolate sends idles or link pulses, no packet data
// RL9 - isolate still negotiates and brings up receive link
// RL10 - indicator mode select: link only, or link plus activity blink
// RL11 - 10 Mb/s link up after seven pulses or one good packet
// RL12 - indicator polarity follows negotiation strap at reset
// RL13 - direct indicator register at 18h, never reads pin state
// RL14 - half duplex: carrier sense on transmit and receive
// RL15 - full duplex: no collision, carrier sense on receive only
// RL16 - parallel detect resolves to half duplex
// RL17 - basic control bit 14 loops transmit to receive, status bit 3
// RL18 - software should disable negotiation before loopback
// RL19 - self test sends 9 or 15 bit prbs, checker compares
// RL20 - self-test status resets fail, latches miscompare, cleared by start write
// RL21 - diag control bit 5 selects continuous self test
// RL22 - self-test error count in diag control bits 15:8
`timescale 1ns/1ps
`include "pcdc_defs.vh"
module pcdc_phy_config_diag #(
  parameter [21:0] BLINK_DIV = `PCDC_BLINK_DIV
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RESETN,
  // straps, sampled while reset is low
  input wire [4:0] MGMT_ADDRESS_STRAP,
  input wire NEGOTIATION_MODE_STRAP,
  input wire INDICATOR_MODE_STRAP,
  // management register port
  input wire [4:0] MGMT_PHY_ADDR,
  input wire [4:0] MGMT_REG_ADDR,
  input wire MGMT_WR,
  input wire MGMT_RD,
  input wire [15:0] MGMT_WDATA,
  output reg [15:0] MGMT_RDATA,
  output reg MGMT_RVALID,
  // mac transmit side
  input wire [3:0] TXD,
  input wire TX_EN,
  input wire TX_CLK_IN,
  output wire TX_CLK_O,
  output wire TX_CLK_OE,
  // mac receive side
  output wire [3:0] RXD_O,
  output wire RX_DV_O,
  output wire RX_ER_O,
  output wire CRS_O,
  output wire COL_O,
  output wire MAC_OE,
  // media side
  input wire [3:0] MEDIA_RXD,
  input wire MEDIA_RX_DV,
  input wire MEDIA_RX_ER,
  input wire MEDIA_SIGNAL_DETECT,
  input wire MEDIA_LINK_PULSE,
  input wire MEDIA_GOOD_PACKET,
  input wire LINK_LOSS,
  input wire SPEED_100,
  input wire AN_FULL_DUPLEX,
  input wire PARALLEL_DETECT,
  output reg [3:0] MEDIA_TXD,
  output reg MEDIA_TX_EN,
  output wire MEDIA_SEND_IDLE,
  // indicator
  output wire LINK_INDICATOR_OUT,
  // status
  output wire ISOLATE,
  output wire LINK_UP,
  output wire FULL_DUPLEX
);
  reg [4:0] addr_reg;
  reg strap_iso_reg;
  reg ind_pol_low_reg;
  reg [15:0] basic_ctrl_reg;
  reg [1:0] ind_direct_reg;
  reg ind_mode_reg;
  reg long_prbs_reg;
  reg st_start_reg;
  reg st_pass_reg;
  reg st_fail_latch_reg;
  reg cont_mode_reg;
  reg [7:0] err_cnt_reg;
  reg [3:0] pulse_cnt_reg;
  reg link10_reg;
  reg [21:0] blink_cnt_reg;
  reg blink_reg;
  reg [14:0] gen_reg;
  reg [14:0] chk_reg;
  reg [15:0] rdata_next;
  wire hit;
  wire wr;
  wire loopback;
  wire half;
  wire activity;
  reg ind_on;
  wire gen_bit;
  wire chk_bit;
  wire [3:0] rx_data;
  wire rx_valid;
  wire crs_raw;
  wire rd_hit;
  wire st_clear;
  wire an_full;
  wire blink_tick;
  reg [3:0] media_txd_next;
  reg media_tx_en_next;
  // straps land during reset so any reset re-captures them
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      addr_reg <= MGMT_ADDRESS_STRAP; // see RL1, RL4 (pads pull to 00001)
      ind_mode_reg <= INDICATOR_MODE_STRAP; // see RL10
    end else if (st_clear) begin
      // written address only steers decode, never isolation
      addr_reg <= MGMT_WDATA[4:0]; // see RL3
      ind_mode_reg <= MGMT_WDATA[`PCDC_PC_IND_MODE];
    end
  end
  // isolate strap and indicator polarity freeze once reset lifts
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      strap_iso_reg <= (MGMT_ADDRESS_STRAP == 5'h00); // see RL3
      ind_pol_low_reg <= NEGOTIATION_MODE_STRAP; // see RL12
    end
  end
  assign hit = (MGMT_PHY_ADDR == addr_reg); // see RL2, RL7
  assign wr = MGMT_WR && hit;
  assign rd_hit = MGMT_RD && hit;
  // any phy control write restarts self-test bookkeeping
  assign st_clear = wr && (MGMT_REG_ADDR == `PCDC_ADDR_PHY_CTRL);
  assign ISOLATE = strap_iso_reg | basic_ctrl_reg[`PCDC_BC_ISOLATE]; // see RL3, RL5
  assign loopback = basic_ctrl_reg[`PCDC_BC_LOOPBACK];
  // parallel detect cannot see partner duplex, so force half
  assign an_full = AN_FULL_DUPLEX & ~PARALLEL_DETECT; // see RL16
  // forced duplex bit counts only with negotiation off
  assign FULL_DUPLEX = basic_ctrl_reg[`PCDC_BC_AN_ENABLE] ? an_full :
    basic_ctrl_reg[`PCDC_BC_DUPLEX];
  assign half = ~FULL_DUPLEX;
  // control registers
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      basic_ctrl_reg <= `PCDC_BASIC_CTRL_RST;
      ind_direct_reg <= 2'h0;
      long_prbs_reg <= 1'b0;
      st_start_reg <= 1'b0;
      cont_mode_reg <= 1'b0;
    end else if (wr) begin
      case (MGMT_REG_ADDR)
        `PCDC_ADDR_BASIC_CTRL: basic_ctrl_reg <= MGMT_WDATA; // see RL5, RL17
        `PCDC_ADDR_IND_DIRECT: begin
          ind_direct_reg <= {MGMT_WDATA[`PCDC_ID_FORCE_EN], MGMT_WDATA[`PCDC_ID_FORCE_VAL]};
        end
        `PCDC_ADDR_PHY_CTRL: begin
          long_prbs_reg <= MGMT_WDATA[`PCDC_PC_LONG_PRBS];
          st_start_reg <= MGMT_WDATA[`PCDC_PC_SELFTEST_START];
        end
        `PCDC_ADDR_DIAG_CTRL: cont_mode_reg <= MGMT_WDATA[`PCDC_DC_CONT_MODE]; // see RL21
        default: ;
      endcase
    end
  end
  // read path; isolate does not gate it
  always @* begin
    rdata_next = 16'h0000;
    case (MGMT_REG_ADDR)
      `PCDC_ADDR_BASIC_CTRL: rdata_next = basic_ctrl_reg;
      `PCDC_ADDR_PHY_STATUS: begin
        rdata_next[0] = LINK_UP;
        rdata_next[1] = ~SPEED_100;
        rdata_next[2] = FULL_DUPLEX;
        rdata_next[`PCDC_PS_LOOPBACK] = loopback; // see RL17
      end
      // direct register returns what was written, not the pin
      `PCDC_ADDR_IND_DIRECT: begin
        rdata_next[`PCDC_ID_FORCE_EN] = ind_direct_reg[1]; // see RL13
        rdata_next[`PCDC_ID_FORCE_VAL] = ind_direct_reg[0];
      end
      `PCDC_ADDR_PHY_CTRL: begin
        rdata_next[4:0] = addr_reg;
        rdata_next[`PCDC_PC_IND_MODE] = ind_mode_reg;
        rdata_next[`PCDC_PC_LONG_PRBS] = long_prbs_reg;
        rdata_next[`PCDC_PC_SELFTEST_STATUS] = st_pass_reg; // see RL20
        rdata_next[`PCDC_PC_SELFTEST_START] = st_start_reg;
      end
      `PCDC_ADDR_DIAG_CTRL: begin
        rdata_next[15:8] = err_cnt_reg; // see RL22
        rdata_next[`PCDC_DC_CONT_MODE] = cont_mode_reg;
      end
      default: rdata_next = 16'h0000;
    endcase
  end
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      MGMT_RDATA <= 16'h0000;
      MGMT_RVALID <= 1'b0;
    end else begin
      MGMT_RVALID <= rd_hit;
      if (rd_hit) begin
        MGMT_RDATA <= rdata_next;
      end
    end
  end
  // 10 Mb/s link qualification, kept alive in isolate
  // loss timer lives outside; LINK_LOSS drops the link at once
  always @(posedge SYS_CLK) begin
    if (!RESETN || LINK_LOSS) begin
      pulse_cnt_reg <= 4'h0;
      link10_reg <= 1'b0;
    end else if (MEDIA_GOOD_PACKET) begin
      link10_reg <= 1'b1; // see RL11, RL9
    end else if (MEDIA_LINK_PULSE) begin
      if (pulse_cnt_reg == `PCDC_LINK_PULSES - 4'h1) begin
        link10_reg <= 1'b1; // see RL11
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
      end
    end
  end
  assign LINK_UP = SPEED_100 ? MEDIA_SIGNAL_DETECT : link10_reg; // see RL9
  // activity blink divider; a slow enable rather than a second clock
  assign activity = TX_EN | MEDIA_RX_DV;
  assign blink_tick = (blink_cnt_reg == BLINK_DIV - 22'h000001);
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      blink_cnt_reg <= 22'h000000;
    end else if (blink_tick) begin
      blink_cnt_reg <= 22'h000000;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 22'h000001;
    end
  end
  // the blink phase only moves on the one-cycle tick
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      blink_reg <= 1'b0;
    end else if (blink_tick) begin
      blink_reg <= ~blink_reg;
    end
  end
  // direct control overrides both indicator modes
  always @* begin
    ind_on = 1'b0;
    if (ind_direct_reg[1]) begin
      ind_on = ind_direct_reg[0]; // see RL13
    end else if (ind_mode_reg) begin
      ind_on = LINK_UP; // see RL10
    end else begin
      // blink only dims a good link, never lights a dead one
      ind_on = LINK_UP & ~(activity & blink_reg); // see RL10, RL11
    end
  end
  assign LINK_INDICATOR_OUT = ind_on ^ ind_pol_low_reg; // see RL12
  // self test prbs: x^9+x^5+1 or x^15+x^14+1
  assign gen_bit = long_prbs_reg ? (gen_reg[14] ^ gen_reg[13]) :
    (gen_reg[8] ^ gen_reg[4]); // see RL19
  assign chk_bit = long_prbs_reg ? (chk_reg[14] ^ chk_reg[13]) :
    (chk_reg[8] ^ chk_reg[4]);
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      gen_reg <= 15'h7fff;
    end else if (st_start_reg || cont_mode_reg) begin
      gen_reg <= {gen_reg[13:0], gen_bit}; // see RL21
    end
  end
  // history keeps shifting through a clear, so the checker stays in step
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      chk_reg <= 15'h0000;
    end else if (st_start_reg && rx_valid) begin
      chk_reg <= {chk_reg[13:0], rx_data[0]}; // see RL19
    end
  end
  // checker self-synchronises from received bits, compares prediction
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_pass_reg <= 1'b0;
      st_fail_latch_reg <= 1'b0;
      err_cnt_reg <= 8'h00;
    end else if (st_clear) begin
      st_pass_reg <= 1'b0; // see RL20
      st_fail_latch_reg <= 1'b0;
      err_cnt_reg <= 8'h00;
    end else if (st_start_reg && rx_valid) begin
      if (rx_data[0] != chk_bit) begin
        st_pass_reg <= 1'b0; // see RL20
        st_fail_latch_reg <= 1'b1;
        // saturate so a long soak never wraps back to zero
        if (err_cnt_reg != 8'hff) begin
          err_cnt_reg <= err_cnt_reg + 8'h01; // see RL22
        end
      end else if (!st_fail_latch_reg) begin
        st_pass_reg <= 1'b1; // see RL20
      end
    end
  end
  // loopback or media receive toward the mac
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_rx_sel
      assign rx_data[gi] = loopback ? TXD[gi] : MEDIA_RXD[gi]; // see RL17
    end
  endgenerate
  assign rx_valid = loopback ? TX_EN : MEDIA_RX_DV;
  assign RXD_O = rx_data;
  assign RX_DV_O = rx_valid;
  assign RX_ER_O = loopback ? 1'b0 : MEDIA_RX_ER;
  assign crs_raw = MEDIA_RX_DV | (half & TX_EN); // see RL14, RL15
  assign CRS_O = loopback ? TX_EN : crs_raw;
  assign COL_O = half & ~loopback & TX_EN & MEDIA_RX_DV; // see RL15
  assign TX_CLK_O = TX_CLK_IN;
  assign TX_CLK_OE = ~ISOLATE; // see RL6
  assign MAC_OE = ~ISOLATE; // see RL6
  // media transmit; idles keep the far end's link alive
  assign MEDIA_SEND_IDLE = ~MEDIA_TX_EN; // see RL8
  // pattern or mac data; isolate and loopback keep data off the media
  always @* begin
    media_txd_next = TXD;
    media_tx_en_next = TX_EN & ~ISOLATE & ~loopback; // see RL6, RL8, RL17
    if (st_start_reg || cont_mode_reg) begin
      media_txd_next = {3'h0, gen_bit};
      media_tx_en_next = ~loopback & ~ISOLATE; // see RL8, RL21
    end
  end
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      MEDIA_TXD <= 4'h0;
      MEDIA_TX_EN <= 1'b0;
    end else begin
      MEDIA_TXD <= media_txd_next;
      MEDIA_TX_EN <= media_tx_en_next;
    end
  end
endmodule

// [rtl/pcdc_defs.vh]
// register offsets, field positions and reset values for the phy config/diag block
// assumes inclusion by the one design file that needs it
`ifndef PCDC_DEFS_VH
`define PCDC_DEFS_VH
`define PCDC_ADDR_BASIC_CTRL 5'h00
`define PCDC_ADDR_PHY_STATUS 5'h10
`define PCDC_ADDR_IND_DIRECT 5'h18
`define PCDC_ADDR_PHY_CTRL 5'h19
`define PCDC_ADDR_DIAG_CTRL 5'h1b
`define PCDC_BC_LOOPBACK 14
`define PCDC_BC_AN_ENABLE 12
`define PCDC_BC_ISOLATE 10
`define PCDC_BC_DUPLEX 8
`define PCDC_PS_LOOPBACK 3
`define PCDC_PC_SELFTEST_START 8
`define PCDC_PC_SELFTEST_STATUS 7
`define PCDC_PC_LONG_PRBS 6
`define PCDC_PC_IND_MODE 5
`define PCDC_ID_FORCE_EN 4
`define PCDC_ID_FORCE_VAL 1
`define PCDC_DC_CONT_MODE 5
`define PCDC_BASIC_CTRL_RST 16'h1000
`define PCDC_LINK_PULSES 4'h7
`define PCDC_BLINK_DIV 22'h2625a0
`endif

// [tb/pcdc_properties.sv]
// concurrent checks on the phy config/diag block ports
// assumes binding to the top design module, one clock domain
`timescale 1ns/1ps
module pcdc_properties (
  // clock, reset, straps
  input wire SYS_CLK,
  input wire RESETN,
  input wire [4:0] MGMT_ADDRESS_STRAP,
  // management and mac
  input wire MGMT_RD,
  input wire MGMT_RVALID,
  input wire TX_EN,
  input wire CRS_O,
  input wire COL_O,
  input wire MAC_OE,
  input wire TX_CLK_OE,
  // media and status
  input wire PARALLEL_DETECT,
  input wire MEDIA_GOOD_PACKET,
  input wire LINK_LOSS,
  input wire SPEED_100,
  input wire MEDIA_TX_EN,
  input wire ISOLATE,
  input wire LINK_UP,
  input wire FULL_DUPLEX
);
  reg [4:0] strap_reg;
  // last strap seen in reset wins, as in the block
  always @(posedge SYS_CLK) if (!RESETN) strap_reg <= MGMT_ADDRESS_STRAP;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  AST_ISO_STRAP: assert property ($rose(RESETN) |-> ISOLATE == (strap_reg == 5'h00))
    else $error("isolate wrong after reset");
  AST_ISO_OE: assert property (ISOLATE |-> !MAC_OE && !TX_CLK_OE)
    else $error("mac outputs driven in isolate");
  AST_ISO_TX: assert property (ISOLATE |=> !MEDIA_TX_EN)
    else $error("media data sent in isolate");
  AST_RVALID: assert property (MGMT_RVALID |-> $past(MGMT_RD))
    else $error("read answer without request");
  AST_HD_CRS: assert property (MAC_OE && !FULL_DUPLEX && TX_EN |-> CRS_O)
    else $error("no carrier on half duplex transmit");
  AST_FD_COL: assert property (FULL_DUPLEX |-> !COL_O)
    else $error("collision in full duplex");
  AST_PD_HALF: assert property (PARALLEL_DETECT |-> !FULL_DUPLEX)
    else $error("parallel detect gave full duplex");
  AST_PKT_LINK: assert property (MEDIA_GOOD_PACKET && !SPEED_100 && !LINK_LOSS
    ##1 !LINK_LOSS && !SPEED_100 |-> LINK_UP)
    else $error("good packet gave no link");
endmodule
bind pcdc_phy_config_diag pcdc_properties u_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .MGMT_ADDRESS_STRAP(MGMT_ADDRESS_STRAP), .MGMT_RD(MGMT_RD), .MGMT_RVALID(MGMT_RVALID),
  .TX_EN(TX_EN), .CRS_O(CRS_O), .COL_O(COL_O), .MAC_OE(MAC_OE), .TX_CLK_OE(TX_CLK_OE),
  .PARALLEL_DETECT(PARALLEL_DETECT), .MEDIA_GOOD_PACKET(MEDIA_GOOD_PACKET),
  .LINK_LOSS(LINK_LOSS), .SPEED_100(SPEED_100), .MEDIA_TX_EN(MEDIA_TX_EN),
  .ISOLATE(ISOLATE), .LINK_UP(LINK_UP), .FULL_DUPLEX(FULL_DUPLEX));

// [tb/pcdc_media_partner.sv]
// media-side partner: a loopback cable from transmit pair to receive pair
// assumes one clock; bench may command corruption of bit 0
`timescale 1ns/1ps
module pcdc_media_partner (
  // clock
  input wire clk,
  // from the device
  input wire [3:0] txd,
  input wire tx_en,
  // control, and back to the device
  input wire corrupt,
  output reg [3:0] rxd,
  output reg rx_dv
);
  initial begin
    rxd = 4'h0;
    rx_dv = 1'b0;
  end
  // idle line inverts rxd every cycle, alternating inverse and copy of last nibble
  always @(posedge clk) begin
    rx_dv <= tx_en;
    rxd <= tx_en ? txd ^ {3'h0, corrupt} : ~rxd;
  end
endmodule

// [tb/phy_config_diag_control_test.sv]
// register-level bench for the phy config/diag block
// assumes media loopback partner and inputs changed on falling edges
`timescale 1ns/1ps
module phy_config_diag_control_test;
  reg SYS_CLK = 1'b0, RESETN = 1'b0, NEG_S = 1'b0, MGMT_WR = 1'b0, MGMT_RD = 1'b0;
  reg [4:0] STRAP = 5'h01, PA = 5'h01, RA = 5'h00;
  reg [15:0] WD = 16'h0000, rdata;
  reg [3:0] TXD = 4'h0;
  reg TX_EN = 1'b0, PULSE = 1'b0, GOOD = 1'b0, LOSS = 1'b0, PD = 1'b0, ANFD = 1'b0, BAD = 1'b0;
  wire [15:0] RDATA;
  wire [3:0] RXD_O, MTXD, MRXD;
  wire RV, RX_DV_O, CRS_O, COL_O, MAC_OE, MTXEN, MRXDV, IND, ISOLATE, LINK_UP, FD, IDLE;
  integer n_mismatch = 0, samples_checked = 0, k;
  always #10 SYS_CLK = ~SYS_CLK;
  pcdc_phy_config_diag #(.BLINK_DIV(22'h000004)) DUT (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .MGMT_ADDRESS_STRAP(STRAP), .NEGOTIATION_MODE_STRAP(NEG_S), .INDICATOR_MODE_STRAP(1'b0),
    .MGMT_PHY_ADDR(PA), .MGMT_REG_ADDR(RA), .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD),
    .MGMT_WDATA(WD), .MGMT_RDATA(RDATA), .MGMT_RVALID(RV), .TXD(TXD), .TX_EN(TX_EN),
    .TX_CLK_IN(SYS_CLK), .TX_CLK_O(), .TX_CLK_OE(), .RXD_O(RXD_O), .RX_DV_O(RX_DV_O),
    .RX_ER_O(), .CRS_O(CRS_O), .COL_O(COL_O), .MAC_OE(MAC_OE), .MEDIA_RXD(MRXD),
    .MEDIA_RX_DV(MRXDV), .MEDIA_RX_ER(1'b0), .MEDIA_SIGNAL_DETECT(1'b0),
    .MEDIA_LINK_PULSE(PULSE), .MEDIA_GOOD_PACKET(GOOD), .LINK_LOSS(LOSS), .SPEED_100(1'b0),
    .AN_FULL_DUPLEX(ANFD), .PARALLEL_DETECT(PD), .MEDIA_TXD(MTXD), .MEDIA_TX_EN(MTXEN),
    .MEDIA_SEND_IDLE(IDLE), .LINK_INDICATOR_OUT(IND), .ISOLATE(ISOLATE), .LINK_UP(LINK_UP),
    .FULL_DUPLEX(FD));
  pcdc_media_partner u_media (.clk(SYS_CLK), .txd(MTXD), .tx_en(MTXEN), .corrupt(BAD),
    .rxd(MRXD), .rx_dv(MRXDV));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task rst(input [4:0] s, input n);
    begin
      STRAP = s;
      NEG_S = n;
      RESETN = 1'b0;
      cyc(8);
      RESETN = 1'b1;
      PA = s;
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      RA = a;
      WD = d;
      MGMT_WR = 1'b1;
      cyc(1);
      MGMT_WR = 1'b0;
      cyc(1);
    end
  endtask
  // answer stands one cycle: sampled right after it rises
  task rd(input [4:0] a, input [15:0] e, input [15:0] m);
    begin
      RA = a;
      MGMT_RD = 1'b1;
      cyc(1);
      MGMT_RD = 1'b0;
      rdata = RDATA;
      if (e !== 16'hffff) chk1(RV, 1'b1);
      if (e !== 16'hffff) chk(rdata & m, e);
    end
  endtask
  task pulses(input integer n);
    repeat (n) begin
      PULSE = 1'b1;
      cyc(1);
      PULSE = 1'b0;
      cyc(1);
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
  initial begin
    rst(5'h01, 1'b0);
    rd(5'h19, 16'h0001, 16'hffff);
    chk1(ISOLATE, 1'b0);
    rd(5'h03, 16'h0000, 16'hffff);
    PA = 5'h02;
    rd(5'h19, 16'hffff, 16'hffff);
    chk1(RV, 1'b0);
    PA = 5'h01;
    wr(5'h00, 16'h0400);
    chk1(ISOLATE & ~MAC_OE, 1'b1);
    rd(5'h00, 16'h0400, 16'hffff);
    $display("address and isolate done");
    rst(5'h00, 1'b0);
    chk1(ISOLATE, 1'b1);
    chk1(IDLE, 1'b1);
    pulses(6);
    chk1(LINK_UP, 1'b0);
    pulses(1);
    chk1(LINK_UP, 1'b1);
    wr(5'h18, 16'h0012);
    chk1(IND, 1'b1);
    rd(5'h18, 16'h0012, 16'hffff);
    rst(5'h03, 1'b0);
    rd(5'h19, 16'h0003, 16'h001f);
    wr(5'h19, 16'h0020);
    PA = 5'h00;
    chk1(ISOLATE, 1'b0);
    GOOD = 1'b1;
    cyc(1);
    GOOD = 1'b0;
    cyc(1);
    chk1(IND, 1'b1);
    $display("link and indicator done");
    wr(5'h00, 16'h0100);
    TX_EN = 1'b1;
    cyc(1);
    chk1(FD & ~CRS_O & ~COL_O, 1'b1);
    wr(5'h00, 16'h1000);
    ANFD = 1'b1;
    PD = 1'b1;
    cyc(1);
    chk1(FD | ~CRS_O, 1'b0);
    PD = 1'b0;
    wr(5'h00, 16'h4000);
    TXD = 4'ha;
    cyc(1);
    chk({11'h0, RX_DV_O, RXD_O}, 16'h001a);
    chk1(MTXEN, 1'b0);
    rd(5'h10, 16'h0008, 16'h0008);
    TX_EN = 1'b0;
    wr(5'h00, 16'h0000);
    $display("duplex and loopback done");
    for (k = 0; k < 2; k = k + 1) begin
      wr(5'h19, 16'h0100 | (k << 6));
      cyc(200);
      wr(5'h19, 16'h0100 | (k << 6));
      cyc(200);
      rd(5'h19, 16'h0080, 16'h0080);
      rd(5'h1b, 16'h0000, 16'hff00);
      BAD = 1'b1;
      cyc(20);
      BAD = 1'b0;
      cyc(50);
      rd(5'h19, 16'h0000, 16'h0080);
      rd(5'h1b, 16'hffff, 16'hffff);
      chk1(rdata[15:8] == 8'h00, 1'b0);
    end
    wr(5'h19, 16'h0000);
    rd(5'h1b, 16'h0000, 16'hff00);
    wr(5'h1b, 16'h0020);
    cyc(4);
    chk1(MTXEN, 1'b1);
    $display("self test done");
    rst(5'h01, 1'b1);
    wr(5'h18, 16'h0012);
    chk1(IND, 1'b0);
    $display("polarity done");
    wrap_up;
  end
endmodule
